// ### pkg/scaling_defines.svh
// Register offsets, field positions, reset values and fixed constants
`ifndef SCALING_DEFINES_SVH
`define SCALING_DEFINES_SVH

// ==========================================================
// Register byte offsets
`define OFS_CTRL        12'h000
`define OFS_LOW         12'h004
`define OFS_HIGH        12'h008
`define OFS_RESULT      12'h00c
`define OFS_STATUS      12'h010
`define OFS_CODE        12'h014
`define OFS_KEY         12'h018
`define OFS_SERVICE     12'h01c
`define PAGE_X          4'h1
`define PAGE_Y          4'h2

// ==========================================================
// Field positions
`define CTRL_RANGE_BIT  0
`define CTRL_CHAR_LSB   1
`define CTRL_EDIT_BIT   3
`define CTRL_CNT_LSB    4
`define STAT_BUSY_BIT   0
`define STAT_ERR_BIT    1
`define STAT_PROMPT_BIT 2
`define STAT_SERVICE_MENU_BIT   3
`define KEY_ENTER_BIT   0
`define KEY_ESC_BIT     1

// ==========================================================
// Reset (factory) values
`define CTRL_RESET      9'h020
`define LOW_RESET       16'h0000
`define HIGH_RESET      16'h03e8
`define SERVICE_RESET   16'h0000
`define CNT_MIN         5'h02

// ==========================================================
// Arithmetic constants, current in microamps, fractions in Q16
`define OFFSET_4MA_UA   32'sh0000_0fa0
`define SPAN_16MA_UA    24'sh003e80
`define SPAN_20MA_UA    24'sh004e20
`define X_FULL_SCALE    48'sh0000_0000_03e8
`define Q_SHIFT         16
`define ROUND_HALF      64'sh0000_0000_0000_8000
`define RESTORE_CODE    16'h1559

`endif

// ### pkg/scaling_pkg.sv
// Types shared by the scaling datapath
package scaling_pkg;

  // ==========================================================
  // Modes
  typedef enum logic {range_4_20, range_0_20} range_t;
  typedef enum logic [1:0] {
    char_linear, char_square, char_sqrt, char_user
  } char_t;
  typedef enum logic {edit_digit, edit_slide} edit_mode_t;

  // ==========================================================
  // State machines
  typedef enum logic [3:0] {
    st_idle, st_norm_wait, st_shape, st_root_wait, st_search,
    st_seg_div, st_seg_wait, st_scale
  } calc_state_t;
  typedef enum logic {rs_idle, rs_prompt} restore_state_t;

endpackage : scaling_pkg

// ### hw/seq_divider.sv
// Sequential signed divider, quotient truncated toward zero
`timescale 1ns/1ns
module seq_divider #(
  parameter int NW = 64,
  parameter int DW = 24
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 start,
  input  wire logic signed [NW-1:0] num,
  input  wire logic signed [DW-1:0] den,
  output logic signed [NW-1:0]      quo,
  output logic                      done
);

  logic [NW-1:0]         a_reg;
  logic [DW-1:0]         b_reg;
  logic [DW:0]           rem_reg;
  logic [$clog2(NW+1)-1:0] cnt_reg;
  logic                  neg_reg;
  logic                  busy_reg;
  logic [DW:0]           rem_sh;
  logic                  ge;

  // ==========================================================
  // One quotient bit per cycle
  assign rem_sh = {rem_reg[DW-1:0], a_reg[NW-1]};
  assign ge     = rem_sh >= {1'b0, b_reg};
  assign quo    = neg_reg ? -$signed(a_reg) : $signed(a_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_reg    <= '0;
      b_reg    <= '0;
      rem_reg  <= '0;
      cnt_reg  <= '0;
      neg_reg  <= 1'b0;
      busy_reg <= 1'b0;
      done     <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        a_reg    <= num[NW-1] ? NW'(-num) : NW'(num);
        b_reg    <= den[DW-1] ? DW'(-den) : DW'(den);
        neg_reg  <= num[NW-1] ^ den[DW-1];
        rem_reg  <= '0;
        cnt_reg  <= ($clog2(NW+1))'(NW);
        busy_reg <= 1'b1;
      end else if (busy_reg) begin
        rem_reg <= ge ? (rem_sh - {1'b0, b_reg}) : rem_sh;
        a_reg   <= {a_reg[NW-2:0], ge};
        cnt_reg <= cnt_reg - 1'b1;
        if (cnt_reg == 1) begin
          busy_reg <= 1'b0;
          done     <= 1'b1; // Quotient valid from this edge
        end
      end
    end
  end

endmodule : seq_divider

// ### hw/seq_sqrt.sv
// Sequential integer square root, one result bit per cycle
`timescale 1ns/1ns
module seq_sqrt #(
  parameter int W = 36
) (
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           start,
  input  wire logic [W-1:0]   radicand,
  output logic [W/2-1:0]      root,
  output logic                done
);

  logic [W-1:0] op_reg;
  logic [W-1:0] res_reg;
  logic [W-1:0] one_reg;
  logic         busy_reg;
  logic [W-1:0] trial;

  // ==========================================================
  // Classic bit-pair method, no multiplier needed
  assign trial = res_reg + one_reg;
  assign root  = res_reg[W/2-1:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_reg   <= '0;
      res_reg  <= '0;
      one_reg  <= '0;
      busy_reg <= 1'b0;
      done     <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        op_reg   <= radicand;
        res_reg  <= '0;
        one_reg  <= {2'b01, {(W-2){1'b0}}};
        busy_reg <= 1'b1;
      end else if (busy_reg) begin
        if (op_reg >= trial) begin
          op_reg  <= op_reg - trial;
          res_reg <= (res_reg >> 1) + one_reg;
        end else begin
          res_reg <= res_reg >> 1;
        end
        one_reg <= one_reg >> 2;
        if (one_reg[1:0] != 2'b00) begin
          busy_reg <= 1'b0;
          done     <= 1'b1;
        end
      end
    end
  end

endmodule : seq_sqrt

// ### hw/input_scaling.sv
// Input scaling datapath with APB registers and menu gating
`timescale 1ns/1ns
`include "scaling_defines.svh"
module input_scaling #(
  parameter int          MAX_POINTS   = 20,
  parameter logic [15:0] SERVICE_CODE = 16'h0a5a // Arbitrary value
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 meas_valid,
  input  wire logic signed [23:0]   meas_ua,
  output logic signed [31:0]        display_value,
  output logic                      display_valid,
  output logic                      calc_error,
  output scaling_pkg::edit_mode_t   edit_mode,
  output logic                      restore_prompt,
  output logic                      service_open
);
  import scaling_pkg::*;

  // ==========================================================
  // Storage
  logic [8:0]              ctrl_reg;
  logic signed [15:0]      low_reg;
  logic signed [15:0]      high_reg;
  logic signed [15:0]      service_reg;
  logic signed [15:0]      x_mem [0:MAX_POINTS-1];
  logic signed [15:0]      y_mem [0:MAX_POINTS-1];
  restore_state_t          restore_state;
  calc_state_t             calc_state;
  logic signed [31:0]      norm_reg;
  logic signed [31:0]      t_reg;
  logic signed [47:0]      nx_reg;
  logic [4:0]              seg_idx;
  logic                    div_start;
  logic                    root_start;
  logic signed [63:0]      div_num;
  logic signed [23:0]      div_den;
  logic signed [63:0]      div_quo;
  logic                    div_done;
  logic [35:0]             root_rad;
  logic [17:0]             root_val;
  logic                    root_done;

  // ==========================================================
  // Bus decode and strobes
  logic        wr_en;
  logic [31:0] rd_data;
  logic        addr_ok;
  logic [4:0]  tbl_idx;
  logic        tbl_ok;
  logic        restore_go;
  logic [4:0]  cnt_field;
  logic [4:0]  cnt_clamped;

  assign wr_en       = psel && penable && pready && pwrite;
  assign tbl_idx     = paddr[6:2];
  assign tbl_ok      = (tbl_idx < 5'(MAX_POINTS)) && (paddr[7] == 1'b0);
  assign restore_go  = wr_en && (paddr == `OFS_KEY) &&
                       pwdata[`KEY_ENTER_BIT] &&
                       (restore_state == rs_prompt);
  assign cnt_field   = pwdata[`CTRL_CNT_LSB +: 5];
  assign cnt_clamped = (cnt_field < `CNT_MIN) ? `CNT_MIN :
                       (cnt_field > 5'(MAX_POINTS)) ? 5'(MAX_POINTS) :
                       cnt_field;

  // Fields straight from the control flops
  assign edit_mode = edit_mode_t'(ctrl_reg[`CTRL_EDIT_BIT]);

  // Rounds a Q16 value to the nearest whole count
  function automatic logic signed [31:0] round_q16(
    input logic signed [63:0] v
  );
    logic signed [63:0] s;
    s = (v + `ROUND_HALF) >>> `Q_SHIFT;
    return s[31:0];
  endfunction : round_q16

  // Read mux; unmapped offsets answer with an error and zero data
  always_comb begin
    rd_data = 32'h0000_0000;
    addr_ok = 1'b1;
    if (paddr[11:8] == `PAGE_X && tbl_ok) begin
      rd_data = 32'(x_mem[tbl_idx]);
    end else if (paddr[11:8] == `PAGE_Y && tbl_ok) begin
      rd_data = 32'(y_mem[tbl_idx]);
    end else begin
      case (paddr)
        `OFS_CTRL:    rd_data = {23'h000000, ctrl_reg};
        `OFS_LOW:     rd_data = 32'(low_reg);
        `OFS_HIGH:    rd_data = 32'(high_reg);
        `OFS_RESULT:  rd_data = display_value;
        `OFS_STATUS: begin
          rd_data[`STAT_BUSY_BIT]   = calc_state != st_idle;
          rd_data[`STAT_ERR_BIT]    = calc_error;
          rd_data[`STAT_PROMPT_BIT] = restore_prompt;
          rd_data[`STAT_SERVICE_MENU_BIT]   = service_open;
        end
        `OFS_SERVICE: rd_data = service_open ? 32'(service_reg) : 32'h0;
        `OFS_CODE, `OFS_KEY: rd_data = 32'h0000_0000;
        default:      addr_ok = 1'b0;
      endcase
    end
  end

  // One wait state; the flopped answer stands for one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      if (psel && penable && !pready) begin
        pready  <= 1'b1;
        prdata  <= pwrite ? 32'h0000_0000 : rd_data;
        pslverr <= !addr_ok;
      end
    end
  end

  // ==========================================================
  // Configuration, reloaded from factory values on confirmed restore
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg    <= `CTRL_RESET;
      low_reg     <= `LOW_RESET;
      high_reg    <= `HIGH_RESET;
      service_reg <= `SERVICE_RESET;
      for (int i = 0; i < MAX_POINTS; i++) begin
        x_mem[i] <= 16'sh0000;
        y_mem[i] <= 16'sh0000;
      end
    end else if (restore_go) begin
      ctrl_reg    <= `CTRL_RESET;
      low_reg     <= `LOW_RESET;
      high_reg    <= `HIGH_RESET;
      service_reg <= `SERVICE_RESET;
      for (int i = 0; i < MAX_POINTS; i++) begin
        x_mem[i] <= 16'sh0000;
        y_mem[i] <= 16'sh0000;
      end
    end else if (wr_en) begin
      if (paddr[11:8] == `PAGE_X && tbl_ok) begin
        x_mem[tbl_idx] <= pwdata[15:0];
      end else if (paddr[11:8] == `PAGE_Y && tbl_ok) begin
        y_mem[tbl_idx] <= pwdata[15:0];
      end else begin
        case (paddr)
          `OFS_CTRL: ctrl_reg <= {cnt_clamped, pwdata[3:0]};
          `OFS_LOW:  low_reg  <= pwdata[15:0];
          `OFS_HIGH: high_reg <= pwdata[15:0];
          `OFS_SERVICE: begin
            if (service_open) begin
              service_reg <= pwdata[15:0];
            end
          end
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // Factory restore prompt and service access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restore_state  <= rs_idle;
      restore_prompt <= 1'b0;
    end else begin
      case (restore_state)
        rs_idle: begin
          if (wr_en && paddr == `OFS_CODE &&
              pwdata[15:0] == `RESTORE_CODE) begin
            restore_state  <= rs_prompt;
            restore_prompt <= 1'b1;
          end
        end
        rs_prompt: begin
          if (wr_en && paddr == `OFS_KEY &&
              (pwdata[`KEY_ENTER_BIT] || pwdata[`KEY_ESC_BIT])) begin
            restore_state  <= rs_idle;
            restore_prompt <= 1'b0;
          end
        end
        default: begin
          restore_state  <= rs_idle;
          restore_prompt <= 1'b0;
        end
      endcase
    end
  end

  // Escape leaves the service menu; any other code written to the code register shuts it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      service_open <= 1'b0;
    end else if (wr_en && paddr == `OFS_CODE) begin
      service_open <= (pwdata[15:0] == SERVICE_CODE);
    end else if (wr_en && paddr == `OFS_KEY && pwdata[`KEY_ESC_BIT]) begin
      service_open <= 1'b0;
    end
  end

  // ==========================================================
  // Conversion datapath
  logic signed [63:0] sq_full;
  logic signed [63:0] scale_full;
  logic signed [15:0] x_lo;
  logic signed [15:0] x_hi;
  logic signed [15:0] y_lo;
  logic signed [15:0] y_hi;
  logic signed [16:0] dx;
  logic signed [31:0] diff_ua;
  logic [4:0]         last_seg;

  assign sq_full    = 64'(norm_reg) * 64'(norm_reg);
  assign scale_full = 64'(t_reg) * 64'(high_reg - low_reg) +
                      (64'(low_reg) <<< `Q_SHIFT);
  assign x_lo       = x_mem[seg_idx];
  assign x_hi       = x_mem[seg_idx + 5'h01];
  assign y_lo       = y_mem[seg_idx];
  assign y_hi       = y_mem[seg_idx + 5'h01];
  assign dx         = 17'(x_hi) - 17'(x_lo);
  assign last_seg   = ctrl_reg[`CTRL_CNT_LSB +: 5] - 5'h02;
  // Service trim corrects the raw current before normalising
  assign diff_ua    = 32'(meas_ua) + 32'(service_reg) -
                      (ctrl_reg[`CTRL_RANGE_BIT] ? 32'sh0 :
                       `OFFSET_4MA_UA);

  // Samples arriving while a conversion runs are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      calc_state    <= st_idle;
      norm_reg      <= 32'sh0;
      t_reg         <= 32'sh0;
      nx_reg        <= 48'sh0;
      seg_idx       <= 5'h00;
      div_start     <= 1'b0;
      root_start    <= 1'b0;
      div_num       <= 64'sh0;
      div_den       <= 24'sh000001;
      root_rad      <= 36'h0;
      display_value <= 32'sh0;
      display_valid <= 1'b0;
      calc_error    <= 1'b0;
    end else begin
      div_start     <= 1'b0;
      root_start    <= 1'b0;
      display_valid <= 1'b0;
      case (calc_state)
        st_idle: begin
          if (meas_valid) begin
            div_num    <= 64'(diff_ua) <<< `Q_SHIFT;
            div_den    <= ctrl_reg[`CTRL_RANGE_BIT] ?
                          `SPAN_20MA_UA : `SPAN_16MA_UA;
            div_start  <= 1'b1;
            calc_state <= st_norm_wait;
          end
        end
        st_norm_wait: begin
          if (div_done) begin
            norm_reg   <= div_quo[31:0];
            calc_state <= st_shape;
          end
        end
        st_shape: begin
          calc_error <= 1'b0;
          case (char_t'(ctrl_reg[`CTRL_CHAR_LSB +: 2]))
            char_linear: begin
              t_reg      <= norm_reg;
              calc_state <= st_scale;
            end
            char_square: begin
              t_reg      <= sq_full[47:16];
              calc_state <= st_scale;
            end
            char_sqrt: begin
              if (norm_reg < 0) begin
                display_value <= 32'(low_reg);
                display_valid <= 1'b1;
                calc_state    <= st_idle;
              end else begin
                root_rad   <= 36'(norm_reg) << `Q_SHIFT;
                root_start <= 1'b1;
                calc_state <= st_root_wait;
              end
            end
            default: begin
              nx_reg     <= 48'(norm_reg) * `X_FULL_SCALE;
              seg_idx    <= 5'h00;
              calc_state <= st_search;
            end
          endcase
        end
        st_root_wait: begin
          if (root_done) begin
            t_reg      <= 32'(root_val);
            calc_state <= st_scale;
          end
        end
        st_search: begin
          if (seg_idx == last_seg ||
              nx_reg < (48'(x_hi) <<< `Q_SHIFT)) begin
            calc_state <= st_seg_div;
          end else begin
            seg_idx <= seg_idx + 5'h01;
          end
        end
        st_seg_div: begin
          if (dx == 17'sh0) begin
            calc_error <= 1'b1; // Equal X values give no slope
            calc_state <= st_idle;
          end else begin
            div_num    <= 64'(nx_reg - (48'(x_lo) <<< `Q_SHIFT)) *
                          64'(17'(y_hi) - 17'(y_lo));
            div_den    <= 24'(dx);
            div_start  <= 1'b1;
            calc_state <= st_seg_wait;
          end
        end
        st_seg_wait: begin
          if (div_done) begin
            display_value <= round_q16(div_quo +
                             (64'(y_lo) <<< `Q_SHIFT));
            display_valid <= 1'b1;
            calc_state    <= st_idle;
          end
        end
        st_scale: begin
          display_value <= round_q16(scale_full);
          display_valid <= 1'b1;
          calc_state    <= st_idle;
        end
        default: calc_state <= st_idle;
      endcase
    end
  end

  // ==========================================================
  // Shared arithmetic units
  seq_divider #(.NW(64), .DW(24)) u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (div_start),
    .num     (div_num),
    .den     (div_den),
    .quo     (div_quo),
    .done    (div_done)
  );

  seq_sqrt #(.W(36)) u_sqrt (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (root_start),
    .radicand (root_rad),
    .root     (root_val),
    .done     (root_done)
  );

endmodule : input_scaling

// ### verif/input_scaling_assertions.sv
// Port-level checks of the scaling block
`timescale 1ns/1ns
`include "scaling_defines.svh"
module input_scaling_assertions
  import scaling_pkg::*;
#(
  parameter logic [15:0] SERVICE_CODE = 16'h0a5a // Arbitrary value
) (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [11:0]          paddr,
  input wire logic [31:0]          pwdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic                 meas_valid,
  input wire logic signed [31:0]   display_value,
  input wire logic                 display_valid,
  input wire scaling_pkg::edit_mode_t edit_mode,
  input wire logic                 restore_prompt,
  input wire logic                 service_open
);
  // ==========================================================
  // Completed write strobe
  logic wr_done;
  assign wr_done = psel & penable & pready & pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Bus handshake
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_ready_answer: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  // ==========================================================
  // Display update
  a_valid_pulse: assert property (display_valid |=> !display_valid)
    else $error("display_valid longer than one cycle");
  a_value_held: assert property ($changed(display_value) |-> display_valid)
    else $error("display changed without valid");
  a_calc_time: assert property (meas_valid |=> !display_valid [*8])
    else $error("display too early after sample");
  // ==========================================================
  // Menu behaviour
  a_edit_follow: assert property (wr_done && paddr == `OFS_CTRL |=>
    edit_mode == $past(pwdata[`CTRL_EDIT_BIT]))
    else $error("edit mode not taken from control write");
  a_prompt_arm: assert property (wr_done && paddr == `OFS_CODE &&
    pwdata[15:0] == `RESTORE_CODE |=> restore_prompt)
    else $error("restore prompt not raised");
  a_esc_clear: assert property (wr_done && paddr == `OFS_KEY &&
    pwdata[`KEY_ESC_BIT] |=> !restore_prompt && !service_open)
    else $error("escape did not cancel");
  a_enter_restore: assert property (wr_done && paddr == `OFS_KEY &&
    pwdata[`KEY_ENTER_BIT] && restore_prompt |=>
    !restore_prompt && edit_mode == edit_digit)
    else $error("enter did not restore");
  a_service_gate: assert property (wr_done && paddr == `OFS_CODE |=>
    service_open == ($past(pwdata[15:0]) == SERVICE_CODE))
    else $error("service menu gate wrong");
endmodule : input_scaling_assertions
bind input_scaling input_scaling_assertions #(.SERVICE_CODE(SERVICE_CODE))
  chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .meas_valid(meas_valid),
  .display_value(display_value), .display_valid(display_valid),
  .edit_mode(edit_mode), .restore_prompt(restore_prompt),
  .service_open(service_open));

// ### verif/meas_frontend.sv
// Model of the measurement front end and the display
`timescale 1ns/1ns
module meas_frontend (
  input  wire logic               pclk,
  output logic                    meas_valid,
  output logic signed [23:0]      meas_ua,
  input  wire logic signed [31:0] display_value,
  input  wire logic               display_valid
);
  // ==========================================================
  // Idle at time zero
  initial begin
    meas_valid = 1'b0;
    meas_ua = 24'sh0;
  end
  // Sample after gap idle cycles; data line inverted once released
  task sample(input logic signed [23:0] ua, input int gap,
              output logic [31:0] v, output bit ok);
    int n;
    repeat (gap) @(posedge pclk);
    meas_ua <= ua;
    meas_valid <= 1'b1;
    @(posedge pclk);
    meas_valid <= 1'b0;
    meas_ua <= ~ua;
    ok = 0;
    v = 'x;
    for (n = 0; n < 400 && !ok; n++) begin
      @(posedge pclk);
      if (display_valid === 1'b1) begin
        ok = 1;
        v = display_value;
      end
    end
  endtask : sample
endmodule : meas_frontend

// ### verif/input_scaling_characteristic_tb.sv
// Self-checking bench for the scaling block
`timescale 1ns/1ns
`include "scaling_defines.svh"
module input_scaling_characteristic_tb;
  import scaling_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic meas_valid, display_valid, calc_error, restore_prompt;
  logic service_open;
  logic signed [23:0] meas_ua;
  logic signed [31:0] display_value;
  edit_mode_t edit_mode;
  int fail_count, cmp_count;
  logic [31:0] v;
  bit ok;
  input_scaling dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas_valid(meas_valid), .meas_ua(meas_ua),
    .display_value(display_value), .display_valid(display_valid),
    .calc_error(calc_error), .edit_mode(edit_mode),
    .restore_prompt(restore_prompt), .service_open(service_open));
  meas_frontend fe_u (.pclk(pclk), .meas_valid(meas_valid),
    .meas_ua(meas_ua), .display_value(display_value),
    .display_valid(display_valid));
  always #20 pclk = ~pclk;
  // ==========================================================
  // Compare, report and close
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task finish_test;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  // APB transfer held until pready is sampled high; bounded wait
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Counted here; the run still closes through finish_test at the end
    if (n >= 20) begin
      fail_count++;
      $display("CHECK FAILED t=%0t bus timeout", $time);
    end
    @(posedge pclk);
  endtask : apb
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask : rd
  // Missing display turns into an unknown, which never matches
  task conv(input logic [31:0] c, input logic signed [23:0] ua,
            input logic [31:0] x);
    wr(`OFS_CTRL, c);
    fe_u.sample(ua, 3 * int'(c[2:1]), v, ok);
    chk(v, x);
  endtask : conv
  // ==========================================================
  // Main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'b000;
    paddr = 12'h000;
    pwdata = 32'h0;
    fail_count = 0;
    cmp_count = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`OFS_CTRL, 32'h20, 1'b0);
    rd(`OFS_HIGH, 32'h3e8, 1'b0);
    rd(12'h030, 32'h0, 1'b1);
    $display("reset test done");
    wr(`OFS_LOW, -32'sd300);
    wr(`OFS_HIGH, 32'd1200);
    conv(32'h20, 24'sd10000, 32'd263);
    conv(32'h21, 24'sd10000, 32'd450);
    conv(32'h20, 24'sd22000, 32'd1388);
    conv(32'h22, 24'sd10000, -32'sd89);
    conv(32'h24, 24'sd10000, 32'd619);
    conv(32'h24, 24'sd2500, -32'sd300);
    wr(`OFS_LOW, 32'd1200);
    wr(`OFS_HIGH, -32'sd300);
    conv(32'h20, 24'sd8000, 32'd825);
    $display("characteristic test done");
    wr(12'h104, 32'd500);
    wr(12'h204, 32'd1000);
    wr(12'h108, 32'd1000);
    conv(32'h36, 24'sd6000, 32'd250);
    conv(32'h36, 24'sd16000, 32'd500);
    conv(32'h36, 24'sd22000, -32'sd250);
    conv(32'h36, 24'sd3000, -32'sd125);
    wr(`OFS_CTRL, 32'h10);
    rd(`OFS_CTRL, 32'h20, 1'b0);
    wr(`OFS_CTRL, 32'h1f0);
    rd(`OFS_CTRL, 32'h140, 1'b0);
    $display("table test done");
    wr(`OFS_CTRL, 32'h28);
    chk(edit_mode, edit_slide);
    wr(`OFS_CODE, 32'h1234);
    chk(service_open, 1'b0);
    wr(`OFS_SERVICE, 32'h5);
    rd(`OFS_SERVICE, 32'h0, 1'b0);
    wr(`OFS_CODE, 32'h0a5a);
    chk(service_open, 1'b1);
    rd(`OFS_SERVICE, 32'h0, 1'b0);
    wr(`OFS_SERVICE, 32'h100);
    rd(`OFS_SERVICE, 32'h100, 1'b0);
    wr(`OFS_KEY, 32'h2);
    chk(service_open, 1'b0);
    wr(`OFS_CODE, 32'h1559);
    chk(restore_prompt, 1'b1);
    wr(`OFS_KEY, 32'h2);
    chk(restore_prompt, 1'b0);
    rd(`OFS_LOW, 32'h4b0, 1'b0);
    wr(`OFS_CODE, 32'h1559);
    wr(`OFS_KEY, 32'h1);
    chk(restore_prompt, 1'b0);
    rd(`OFS_CTRL, 32'h20, 1'b0);
    conv(32'h20, 24'sd12000, 32'd500);
    wr(`OFS_CTRL, 32'h26);
    fe_u.sample(24'sd12000, 0, v, ok);
    chk({31'h0, ok}, 32'h0);
    chk(calc_error, 1'b1);
    rd(`OFS_STATUS, 32'h2, 1'b0);
    rd(`OFS_RESULT, 32'd500, 1'b0);
    $display("menu test done");
    finish_test();
  end
endmodule : input_scaling_characteristic_tb
